// File: verilog/dpc_top.sv
// dpc_top: dma data path configuration register and its steering logic
`timescale 1ns/1ps
// Notes on behaviour
// - width bit picks byte or word transfers
// - word mode: 32k words, address bit zero low
// - order bit clear: msb upper lane, else swapped
// - byte mode ignores the byte order bit
// - long address bit: dual 16 or single 32
// - 32-bit mode drives remote start as upper address
// - long address bit set at power up
// - loopback bit clear means loopback, set normal
// - auto remote gates the send packet command
// - threshold code sets request level and burst
// - codes mean 1,2,4,6 words or 2,4,8,12 bytes
// - receive: request once fifo holds threshold
// - transmit: request point 13 bytes less the receive threshold
module dpc_top #(
    parameter int LANE_W = 8,
    parameter int FIFO_DEPTH = dpc_pkg::FIFO_BYTES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [dpc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dpc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dpc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0] remote_start_low,
    input wire logic [7:0] remote_start_high,
    input wire logic [LANE_W-1:0] dma_msb_byte,
    input wire logic [LANE_W-1:0] dma_lsb_byte,
    input wire logic receiving,
    input wire logic transmitting,
    input wire logic [dpc_pkg::LEVEL_W-1:0] rx_fifo_level,
    input wire logic [dpc_pkg::LEVEL_W-1:0] tx_fifo_level,
    input wire logic send_packet_cmd,
    output logic [LANE_W-1:0] muxed_bus_upper_lane,
    output logic [LANE_W-1:0] muxed_bus_lower_lane,
    output logic [15:0] addr_out,
    output logic [15:0] upper_address_lines,
    output logic word_mode,
    output logic long_address_mode,
    output logic loopback_active,
    output logic auto_remote_en,
    output logic [3:0] burst_len,
    output logic bus_request_out,
    output logic remote_autoinit
);
    import dpc_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the threshold tables and the 13-byte offset assume these sizes
    generate
        if (LANE_W != 8) begin : g_bad_lane
            $error("dpc_top: LANE_W must be 8");
        end
        if (FIFO_DEPTH != FIFO_BYTES) begin : g_bad_depth
            $error("dpc_top: FIFO_DEPTH must equal the fifo byte depth");
        end
    endgenerate

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    logic [CFG_BITS-1:0] data_path_config; // stored config, seven live bits
    logic send_refused;                    // sticky: send command dropped

    // write decode for the config register
    wire logic cfg_hit;
    assign cfg_hit = reg_wr && (reg_addr == OFF_DATA_PATH_CONFIG);

    // status read decode, clears the sticky bit
    wire logic status_rd;
    assign status_rd = reg_rd && (reg_addr == OFF_PATH_STATUS);

    // config store; bit 7 of the write data is dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_path_config <= CFG_RESET; // long address set
        end else if (cfg_hit) begin
            data_path_config <= reg_wdata[CFG_BITS-1:0]; // top bit ignored
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire logic cfg_word;       // word transfers selected
    wire logic cfg_order;      // byte_lane_order as written
    wire logic cfg_long;       // long_address_choice
    wire logic cfg_loop_n;     // loopback_choice, low means loopback
    wire logic cfg_auto;       // auto remote
    wire logic [1:0] thr_code; // fifo_threshold_high, fifo_threshold_low
    assign cfg_word = data_path_config[BIT_WORD_MODE];
    assign cfg_order = data_path_config[BIT_LANE_ORDER];
    assign cfg_long = data_path_config[BIT_LONG_ADDR];
    assign cfg_loop_n = data_path_config[BIT_LOOPBACK];
    assign cfg_auto = data_path_config[BIT_AUTO_REMOTE];
    assign thr_code = {data_path_config[BIT_THR_HIGH], data_path_config[BIT_THR_LOW]};

    // order only counts in word mode
    wire logic eff_swap;
    assign eff_swap = cfg_word && cfg_order;

    // ------------------------------------------------------------
    // threshold tables
    // ------------------------------------------------------------
    // threshold in transfers: words in word mode, bytes in byte mode
    wire logic [3:0] thr_words;
    wire logic [3:0] thr_bytes;
    assign thr_words = (thr_code == 2'b00) ? THR_WORDS_0 :
                       (thr_code == 2'b01) ? THR_WORDS_1 :
                       (thr_code == 2'b10) ? THR_WORDS_2 : THR_WORDS_3;
    assign thr_bytes = (thr_code == 2'b00) ? THR_BYTES_0 :
                       (thr_code == 2'b01) ? THR_BYTES_1 :
                       (thr_code == 2'b10) ? THR_BYTES_2 : THR_BYTES_3;

    // burst length in transfers of the selected width
    wire logic [3:0] next_burst;
    assign next_burst = cfg_word ? thr_words : thr_bytes;

    // receive threshold measured in fifo bytes: same byte count either mode
    wire logic [LEVEL_W-1:0] rx_thr;
    assign rx_thr = {1'b0, thr_bytes};

    // transmit point: 13 bytes less the receive threshold
    wire logic [LEVEL_W-1:0] tx_thr;
    assign tx_thr = TX_THR_OFFSET - rx_thr;

    // ------------------------------------------------------------
    // bus request
    // ------------------------------------------------------------
    // receive: fifo filled from the network to the threshold
    wire logic rx_req;
    assign rx_req = receiving && (rx_fifo_level >= rx_thr);

    // transmit: fifo drained to the transmit point, local dma refills
    wire logic tx_req;
    assign tx_req = transmitting && (tx_fifo_level <= tx_thr);

    // receive side has priority when both report activity
    wire logic next_bus_request_out;
    assign next_bus_request_out = receiving ? rx_req : tx_req;

    // ------------------------------------------------------------
    // address steering
    // ------------------------------------------------------------
    // word mode holds a0 low: 15 address bits, 32k words
    wire logic [15:0] next_addr;
    assign next_addr = cfg_word ? {dma_addr[15:1], 1'b0} : dma_addr;

    // long mode issues the remote start pair as upper_address_lines
    wire logic [15:0] next_upper_addr;
    assign next_upper_addr = cfg_long ? {remote_start_high, remote_start_low} : 16'h0000;

    // ------------------------------------------------------------
    // send packet command
    // ------------------------------------------------------------
    // honoured only with auto remote set; otherwise dropped and flagged
    wire logic send_ok;
    wire logic send_drop;
    assign send_ok = send_packet_cmd && cfg_auto;
    assign send_drop = send_packet_cmd && !cfg_auto;

    // ------------------------------------------------------------
    // status readback
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] status_word;
    assign status_word = {1'b0,
                          send_refused,
                          bus_request_out,
                          cfg_auto,
                          !cfg_loop_n,
                          cfg_long,
                          eff_swap,
                          cfg_word};

    // read mux: config is write-only, unmapped reads give zero
    wire logic [DATA_W-1:0] next_rdata;
    assign next_rdata = status_rd ? status_word : 8'h00;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // mode flags seen by the dma counters and the network side
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_mode <= 1'b0;
            long_address_mode <= 1'b1;
            loopback_active <= 1'b0;
            auto_remote_en <= 1'b0;
            burst_len <= 4'h0;
        end else begin
            word_mode <= cfg_word;
            long_address_mode <= cfg_long;
            loopback_active <= !cfg_loop_n;
            auto_remote_en <= cfg_auto;
            burst_len <= next_burst;
        end
    end

    // bus request and address lines
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_request_out <= 1'b0;
            addr_out <= 16'h0000;
            upper_address_lines <= 16'h0000;
        end else begin
            bus_request_out <= next_bus_request_out;
            addr_out <= next_addr;
            upper_address_lines <= next_upper_addr;
        end
    end

    // remote auto-init pulse, one cycle per honoured command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            remote_autoinit <= 1'b0;
        end else begin
            remote_autoinit <= send_ok;
        end
    end

    // sticky refused flag: a new drop wins over the read clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            send_refused <= 1'b0;
        end else if (send_drop) begin
            send_refused <= 1'b1;
        end else if (status_rd) begin
            send_refused <= 1'b0;
        end
    end

    // read data, valid the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // byte lane steering
    // ------------------------------------------------------------
    // width and order applied to both local and remote dma data
    dpc_lane_steer #(
        .LANE_W(LANE_W)
    ) u_lane_steer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .word_mode(cfg_word),
        .swap(eff_swap),
        .msb_byte(dma_msb_byte),
        .lsb_byte(dma_lsb_byte),
        .upper_lane(muxed_bus_upper_lane),
        .lower_lane(muxed_bus_lower_lane)
    );

endmodule : dpc_top

// File: include/dpc_pkg.sv
// dpc_pkg: register map, field layout, reset values and threshold tables
package dpc_pkg;

    // ------------------------------------------------------------
    // register port geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;                          // register address width
    localparam int DATA_W = 8;                          // register data width
    localparam logic [4:0] OFF_DATA_PATH_CONFIG = 5'h0E; // write-only config
    localparam logic [4:0] OFF_PATH_STATUS = 5'h1F;      // read-only block state

    // ------------------------------------------------------------
    // data_path_config field positions
    // ------------------------------------------------------------
    localparam int BIT_WORD_MODE = 0;       // byte or word transfers
    localparam int BIT_LANE_ORDER = 1;      // byte_lane_order
    localparam int BIT_LONG_ADDR = 2;       // long_address_choice
    localparam int BIT_LOOPBACK = 3;        // loopback_choice, low = loopback
    localparam int BIT_AUTO_REMOTE = 4;     // auto-initialize remote
    localparam int BIT_THR_LOW = 5;         // fifo_threshold_low
    localparam int BIT_THR_HIGH = 6;        // fifo_threshold_high
    localparam int CFG_BITS = 7;            // stored bits, top bit dropped

    // reset: long address and normal operation, all else clear
    localparam logic [6:0] CFG_RESET = 7'h0C;

    // ------------------------------------------------------------
    // fifo and threshold constants
    // ------------------------------------------------------------
    localparam int FIFO_BYTES = 16;                     // fifo depth in bytes
    localparam int LEVEL_W = 5;                         // fill level width
    localparam logic [4:0] TX_THR_OFFSET = 5'h0D;       // 13 bytes
    localparam logic [3:0] THR_WORDS_0 = 4'h1;          // code 00
    localparam logic [3:0] THR_WORDS_1 = 4'h2;          // code 01
    localparam logic [3:0] THR_WORDS_2 = 4'h4;          // code 10
    localparam logic [3:0] THR_WORDS_3 = 4'h6;          // code 11
    localparam logic [3:0] THR_BYTES_0 = 4'h2;          // code 00
    localparam logic [3:0] THR_BYTES_1 = 4'h4;          // code 01
    localparam logic [3:0] THR_BYTES_2 = 4'h8;          // code 10
    localparam logic [3:0] THR_BYTES_3 = 4'hC;          // code 11

    // ------------------------------------------------------------
    // path_status field positions
    // ------------------------------------------------------------
    localparam int ST_WORD_MODE = 0;        // word transfers in force
    localparam int ST_SWAPPED = 1;          // lanes really swapped
    localparam int ST_LONG_ADDR = 2;        // 32-bit addressing in force
    localparam int ST_LOOPBACK = 3;         // loopback in force
    localparam int ST_AUTO_REMOTE = 4;      // send command honoured
    localparam int ST_BUS_REQ = 5;          // bus request now
    localparam int ST_SEND_REFUSED = 6;     // sticky: send command dropped

endpackage : dpc_pkg

// File: verilog/dpc_lane_steer.sv
// dpc_lane_steer: registered byte-lane steering onto the multiplexed bus
`timescale 1ns/1ps
module dpc_lane_steer #(
    parameter int LANE_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic word_mode,
    input wire logic swap,
    input wire logic [LANE_W-1:0] msb_byte,
    input wire logic [LANE_W-1:0] lsb_byte,
    output logic [LANE_W-1:0] upper_lane,
    output logic [LANE_W-1:0] lower_lane
);

    // ------------------------------------------------------------
    // lane selection
    // ------------------------------------------------------------
    // byte mode: lsb byte alone on the lower lane, upper lane idle
    wire logic [LANE_W-1:0] next_upper;
    wire logic [LANE_W-1:0] next_lower;
    assign next_upper = !word_mode ? '0 : (swap ? lsb_byte : msb_byte);
    assign next_lower = !word_mode ? lsb_byte : (swap ? msb_byte : lsb_byte);

    // output flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            upper_lane <= '0;
            lower_lane <= '0;
        end else begin
            upper_lane <= next_upper;
            lower_lane <= next_lower;
        end
    end

endmodule : dpc_lane_steer

// File: test/dpc_mem_side.sv
// dpc_mem_side: memory side model giving address counter, start address and data bytes
`timescale 1ns/1ps
module dpc_mem_side #(
    parameter logic [7:0] START_LOW = 8'h34,
    parameter logic [7:0] START_HIGH = 8'h12
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic step,
    output logic [15:0] dma_addr,
    output logic [7:0] remote_start_low,
    output logic [7:0] remote_start_high,
    output logic [7:0] dma_msb_byte,
    output logic [7:0] dma_lsb_byte
);
    // bytes differ at every address the bench reaches, so a lane swap always shows
    assign remote_start_low = START_LOW;
    assign remote_start_high = START_HIGH;
    assign dma_msb_byte = dma_addr[15:8] ^ 8'hA5;
    assign dma_lsb_byte = dma_addr[7:0];
    // one byte per step, so odd addresses reach the block
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_addr <= 16'h0100;
        end else if (step) begin
            dma_addr <= dma_addr + 16'h0001;
        end
    end
endmodule : dpc_mem_side

// File: test/dpc_top_props.sv
// dpc_top_props: port-level assertions for the data path config block
`timescale 1ns/1ps
module dpc_top_props #(
    parameter int LANE_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [dpc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dpc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [dpc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [15:0] dma_addr,
    input wire logic [7:0] remote_start_low,
    input wire logic [7:0] remote_start_high,
    input wire logic [LANE_W-1:0] dma_msb_byte,
    input wire logic [LANE_W-1:0] dma_lsb_byte,
    input wire logic receiving,
    input wire logic transmitting,
    input wire logic [dpc_pkg::LEVEL_W-1:0] rx_fifo_level,
    input wire logic [dpc_pkg::LEVEL_W-1:0] tx_fifo_level,
    input wire logic send_packet_cmd,
    input wire logic [LANE_W-1:0] muxed_bus_upper_lane,
    input wire logic [LANE_W-1:0] muxed_bus_lower_lane,
    input wire logic [15:0] addr_out,
    input wire logic [15:0] upper_address_lines,
    input wire logic word_mode,
    input wire logic long_address_mode,
    input wire logic loopback_active,
    input wire logic auto_remote_en,
    input wire logic [3:0] burst_len,
    input wire logic bus_request_out,
    input wire logic remote_autoinit
);
    import dpc_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // shadow of the config, delayed to line up with the outputs
    // ------------------------------------------------------------
    logic [6:0] cfg, cfg_d, cfg_dd;
    logic up; // one edge past reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= 7'h0C;
            cfg_d <= 7'h0C;
            cfg_dd <= 7'h0C;
            up <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == OFF_DATA_PATH_CONFIG) begin
                cfg <= reg_wdata[6:0];
            end
            cfg_d <= cfg;
            cfg_dd <= cfg_d;
            up <= 1'b1;
        end
    end
    // config unchanged long enough that every output agrees on it
    wire steady = (cfg == cfg_d) && (cfg_d == cfg_dd);
    wire [4:0] thr = cfg_d[6] ? (cfg_d[5] ? 5'h0C : 5'h08) : (cfg_d[5] ? 5'h04 : 5'h02);
    wire [3:0] burst = cfg_d[0] ? thr[4:1] : thr[3:0];
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_mode_levels:
        assert property (word_mode == cfg_d[0] && long_address_mode == cfg_d[2]
            && loopback_active == !cfg_d[3] && auto_remote_en == cfg_d[4])
        else $error("mode outputs differ from written config");
    a_burst_length:
        assert property (up |-> burst_len == burst)
        else $error("burst length wrong for threshold code");
    a_bus_request:
        assert property (up && steady |-> bus_request_out == ($past(receiving) ? $past(rx_fifo_level) >= thr
            : $past(transmitting) && $past(tx_fifo_level) <= TX_THR_OFFSET - thr))
        else $error("bus request level wrong");
    a_word_address:
        assert property (up && steady |-> addr_out == {$past(dma_addr[15:1]), $past(dma_addr[0]) & !cfg_d[0]})
        else $error("address out wrong");
    a_upper_lines:
        assert property (up && steady |-> upper_address_lines
            == (cfg_d[2] ? {$past(remote_start_high), $past(remote_start_low)} : 16'h0000))
        else $error("upper address lines wrong");
    a_lane_order:
        assert property (up && steady |-> muxed_bus_upper_lane == (!cfg_d[0] ? '0
            : cfg_d[1] ? $past(dma_lsb_byte) : $past(dma_msb_byte)) && muxed_bus_lower_lane
            == ((cfg_d[0] & cfg_d[1]) ? $past(dma_msb_byte) : $past(dma_lsb_byte)))
        else $error("byte lanes wrong");
    a_send_honoured:
        assert property (send_packet_cmd && steady |=> remote_autoinit == $past(cfg_d[4]))
        else $error("send command handling wrong");
    a_autoinit_pulse:
        assert property (!send_packet_cmd |=> !remote_autoinit)
        else $error("autoinit without send command");
    a_read_idle:
        assert property (!(reg_rd && reg_addr == OFF_PATH_STATUS) |=> reg_rdata == 8'h00)
        else $error("read data not zero");
endmodule : dpc_top_props

bind dpc_top dpc_top_props #(.LANE_W(LANE_W)) i_props (.*);

// File: test/test_dpc_top.sv
// test_dpc_top: directed bench for the data path config block
`timescale 1ns/1ps
module test_dpc_top;
    import dpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic receiving = 1'b0;
    logic transmitting = 1'b0;
    logic [4:0] rx_fifo_level = 5'h00;
    logic [4:0] tx_fifo_level = 5'h00;
    logic send_packet_cmd = 1'b0;
    logic step = 1'b0; // advances the memory side address
    logic [7:0] reg_rdata, remote_start_low, remote_start_high, dma_msb_byte, dma_lsb_byte;
    logic [7:0] muxed_bus_upper_lane, muxed_bus_lower_lane;
    logic [15:0] dma_addr, addr_out, upper_address_lines;
    logic word_mode, long_address_mode, loopback_active, auto_remote_en, bus_request_out, remote_autoinit;
    logic [3:0] burst_len;
    int miscompares = 0;
    int checks_done = 0;
    logic [4:0] thr_tab [4] = '{5'h02, 5'h04, 5'h08, 5'h0C}; // receive threshold in bytes
    always #50 sys_clk = ~sys_clk;
    dpc_top i_dut (.*);
    dpc_mem_side i_mem (.*);
    // ------------------------------------------------------------
    // access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // write also steps the memory side address once
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        step <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        step <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string name);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(name, reg_rdata, exp);
    endtask : rd
    task automatic settle;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic lv(input logic r, input logic t, input logic [4:0] rl, input logic [4:0] tl);
        @(posedge sys_clk);
        receiving <= r;
        transmitting <= t;
        rx_fifo_level <= rl;
        tx_fifo_level <= tl;
        @(posedge sys_clk);
        #1;
    endtask : lv
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // watchdog against a hang
    initial begin
        #5000000;
        miscompares++;
        report_and_stop();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [4:0] thr;
        logic w, au, swp, sent, lb;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle();
        chk("long at reset", long_address_mode, 1'b1);
        chk("burst at reset", burst_len, 4'h2);
        chk("upper at reset", upper_address_lines, {remote_start_high, remote_start_low});
        rd(OFF_PATH_STATUS, 8'h04, "status at reset");
        rd(OFF_DATA_PATH_CONFIG, 8'h00, "write only config");
        rd(5'h03, 8'h00, "unmapped read");
        // every threshold code in both widths, modes varied alongside
        for (int i = 0; i < 8; i++) begin
            w = i[2];
            au = i[1];
            swp = w & i[1];
            lb = !(i[0] ^ i[2]);
            thr = thr_tab[i[1:0]];
            wr(OFF_DATA_PATH_CONFIG, {i[0], i[1:0], au, !lb, i[0], i[1], w});
            settle();
            chk("word", word_mode, w);
            chk("burst", burst_len, w ? thr[4:1] : thr[3:0]);
            chk("long", long_address_mode, i[0]);
            chk("upper addr", upper_address_lines, i[0] ? {remote_start_high, remote_start_low} : 16'h0000);
            chk("loopback", loopback_active, lb);
            chk("auto", auto_remote_en, au);
            chk("addr", addr_out, {dma_addr[15:1], dma_addr[0] & !w});
            chk("upper lane", muxed_bus_upper_lane, !w ? 8'h00 : swp ? dma_lsb_byte : dma_msb_byte);
            chk("lower lane", muxed_bus_lower_lane, swp ? dma_msb_byte : dma_lsb_byte);
            lv(1'b1, 1'b0, thr - 5'h01, 5'h00);
            chk("rx below", bus_request_out, 1'b0);
            lv(1'b1, 1'b0, thr, 5'h00);
            chk("rx at", bus_request_out, 1'b1);
            lv(1'b0, 1'b1, 5'h00, 5'h0D - thr);
            chk("tx at", bus_request_out, 1'b1);
            lv(1'b0, 1'b1, 5'h00, 5'h0E - thr);
            chk("tx above", bus_request_out, 1'b0);
            lv(1'b0, 1'b0, 5'h00, 5'h00);
            sent = !swp; // no send command while lanes are swapped
            if (sent) begin
                @(posedge sys_clk);
                send_packet_cmd <= 1'b1;
                @(posedge sys_clk);
                send_packet_cmd <= 1'b0;
                #1 chk("autoinit", remote_autoinit, au);
            end
            rd(OFF_PATH_STATUS, {1'b0, sent & !au, 1'b0, au, lb, i[0], swp, w}, "status");
        end
        // write elsewhere leaves the config alone
        wr(5'h0D, 8'h00);
        settle();
        chk("config kept", word_mode, 1'b1);
        report_and_stop();
    end
endmodule : test_dpc_top
